/* File: rtl/sfc_regs.vh */
// Register offsets, field positions and reset values of the frequency
// and clock-output configuration registers.
// Assumes inclusion by the design modules of this block only.
`ifndef SFC_REGS_VH
`define SFC_REGS_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define SFC_ADR_FINE 3'h1
`define SFC_ADR_COARSE 3'h2

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SFC_FINE_MSB 7
`define SFC_FINE_LSB 1
`define SFC_OPT_BIT 0
`define SFC_COARSE_MSB 7
`define SFC_COARSE_LSB 2
`define SFC_CLK_EN_BIT 1
`define SFC_CLK_ON_BIT 0
`define SFC_RANGE_BIT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SFC_FINE_RST 8'ha8
`define SFC_COARSE_RST 8'h7b

// ----------------------------------------
// Frequency word constants
// ----------------------------------------
`define SFC_LOW_BASE 13'hc00
`define SFC_STEP_DIV 16384

// ----------------------------------------
// Operating modes
// ----------------------------------------
`define SFC_OPM_TX 3'h1
`define SFC_OPM_RXP 3'h2
`define SFC_OPM_RX 3'h3
`define SFC_OPM_FDM 3'h5
`define SFC_OPM_FDS 3'h7

`endif

/* File: rtl/sfc_word.v */
// Frequency word builder: coarse plus fine value.
// Assumes register contents on the same clock.
`timescale 1ns/1ps
`include "sfc_regs.vh"

module sfc_word (
  input wire range_sel,
  input wire [5:0] coarse_bits,
  input wire [6:0] fine_bits,
  output wire [12:0] coarse_value,
  output wire [12:0] freq_word
);
  // Low range keeps only the lower three coarse bits
  assign coarse_value = range_sel ? {coarse_bits, 7'h00}
                      : (`SFC_LOW_BASE + {3'h0, coarse_bits[2:0], 7'h00});
  assign freq_word = coarse_value + {6'h00, fine_bits};
endmodule // sfc_word

/* File: rtl/sfc_config.v */
// Frequency and clock-output configuration registers, addresses 1 and 2.
// Assumes the serial interface decoder presents single-cycle write and
// read strobes on core_clk; the wake pin is asynchronous.
`timescale 1ns/1ps
`include "sfc_regs.vh"

module sfc_config (
  input wire core_clk,
  input wire reset_n,
  input wire [2:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] ctrl1_value,
  input wire bitcheck_ok,
  input wire active_low_wake_pin,
  input wire power_on_status,
  output reg [7:0] reg_rdata,
  output reg [12:0] freq_word,
  output reg bitcheck_irq,
  output reg manchester_en,
  output reg clk_out_en
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] fine_r;
  reg [7:0] fine_nxt;
  reg [7:0] coarse_r;
  reg [7:0] coarse_nxt;
  reg wake_s1_r;
  reg wake_s2_r;
  reg wake_s3_r;
  reg [7:0] rdata_nxt;
  reg irq_nxt;
  reg manch_nxt;
  reg clk_out_nxt;
  reg full_duplex;
  reg rx_any;
  wire [2:0] opm;
  wire wr_fine;
  wire wr_coarse;
  wire opt_bit;
  wire evt_bitcheck;
  wire evt_wake;
  wire evt_power;
  wire clk_evt;
  wire [12:0] word_nxt;

  // ----------------------------------------
  // Address and field decode
  // ----------------------------------------
  assign opm = ctrl1_value[3:1];
  assign wr_fine = reg_wr && (reg_addr == `SFC_ADR_FINE);
  assign wr_coarse = reg_wr && (reg_addr == `SFC_ADR_COARSE);
  assign opt_bit = fine_r[`SFC_OPT_BIT];

  // ----------------------------------------
  // Operating mode decode
  // ----------------------------------------
  always @* begin
    full_duplex = 1'b0;
    rx_any = 1'b0;
    // Undefined codes behave as idle
    case (opm)
      `SFC_OPM_TX: begin
        rx_any = 1'b0;
      end
      `SFC_OPM_RXP: begin
        rx_any = 1'b1;
      end
      `SFC_OPM_RX: begin
        rx_any = 1'b1;
      end
      `SFC_OPM_FDM: begin
        full_duplex = 1'b1;
      end
      `SFC_OPM_FDS: begin
        full_duplex = 1'b1;
      end
      default: begin
        full_duplex = 1'b0;
        rx_any = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // Wake pin synchroniser and edge
  // ----------------------------------------
  // Reset to the idle level so no false edge follows reset
  always @(posedge core_clk) begin
    if (!reset_n) begin
      wake_s1_r <= 1'b1;
      wake_s2_r <= 1'b1;
      wake_s3_r <= 1'b1;
    end else begin
      wake_s1_r <= active_low_wake_pin;
      wake_s2_r <= wake_s1_r;
      wake_s3_r <= wake_s2_r;
    end
  end

  // ----------------------------------------
  // Clock-active set events
  // ----------------------------------------
  // Wake event is a falling edge of the synchronised pin
  assign evt_bitcheck = bitcheck_ok && rx_any;
  assign evt_wake = wake_s3_r && !wake_s2_r;
  assign evt_power = power_on_status;
  assign clk_evt = evt_bitcheck || evt_wake || evt_power;

  // ----------------------------------------
  // Register writes; hardware set wins
  // ----------------------------------------
  always @* begin
    fine_nxt = fine_r;
    if (wr_fine) begin
      fine_nxt = reg_wdata;
    end
  end

  always @* begin
    coarse_nxt = coarse_r;
    if (wr_coarse) begin
      coarse_nxt = reg_wdata;
    end
    // Set beats a same-cycle write of zero
    if (clk_evt) begin
      coarse_nxt[`SFC_CLK_ON_BIT] = 1'b1;
    end
  end

  always @(posedge core_clk) begin
    if (!reset_n) begin
      fine_r <= `SFC_FINE_RST;
      coarse_r <= `SFC_COARSE_RST;
    end else begin
      fine_r <= fine_nxt;
      coarse_r <= coarse_nxt;
    end
  end

  // ----------------------------------------
  // Frequency word
  // ----------------------------------------
  sfc_word u_word (
    .range_sel(ctrl1_value[`SFC_RANGE_BIT]),
    .coarse_bits(coarse_r[`SFC_COARSE_MSB:`SFC_COARSE_LSB]),
    .fine_bits(fine_r[`SFC_FINE_MSB:`SFC_FINE_LSB]),
    .coarse_value(),
    .freq_word(word_nxt)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    rdata_nxt = reg_rdata;
    if (reg_rd) begin
      // Unmapped addresses read as zero
      case (reg_addr)
        `SFC_ADR_FINE: begin
          rdata_nxt = fine_r;
        end
        `SFC_ADR_COARSE: begin
          rdata_nxt = coarse_r;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Output next values
  // ----------------------------------------
  always @* begin
    irq_nxt = evt_bitcheck && !full_duplex && !opt_bit;
    manch_nxt = !opt_bit;
    if (full_duplex) begin
      manch_nxt = 1'b1;
    end
    clk_out_nxt = 1'b0;
    if (coarse_r[`SFC_CLK_EN_BIT]) begin
      clk_out_nxt = coarse_r[`SFC_CLK_ON_BIT];
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      freq_word <= 13'h0000;
      bitcheck_irq <= 1'b0;
      manchester_en <= 1'b1;
      clk_out_en <= 1'b0;
    end else begin
      reg_rdata <= rdata_nxt;
      freq_word <= word_nxt;
      bitcheck_irq <= irq_nxt;
      manchester_en <= manch_nxt;
      clk_out_en <= clk_out_nxt;
    end
  end
endmodule // sfc_config

/* File: sim/sfc_host.sv */
// Host model: one-cycle register strobes
// Assumes the bench calls xfer
`timescale 1ns/1ps
module sfc_host(input wire core_clk,input wire [7:0] reg_rdata,output reg [2:0] reg_addr=0,
  output reg [7:0] reg_wdata=0,output reg reg_wr=0,output reg reg_rd=0);
  task xfer(input [2:0] a,input [7:0] d,input w,output [7:0] q); begin
    @(posedge core_clk) {reg_addr,reg_wdata,reg_wr,reg_rd}<={a,d,w,!w};
    @(posedge core_clk) {reg_wdata,reg_wr,reg_rd}<={~d,2'h0};
    #1 q=reg_rdata;
  end endtask
endmodule // sfc_host

/* File: sim/sfc_config_checker.sv */
// Port checker for sfc_config
`timescale 1ns/1ps
module sfc_config_chk(input wire core_clk,reset_n,reg_wr,reg_rd,bitcheck_ok,bitcheck_irq,
  manchester_en,clk_out_en,input wire [2:0] reg_addr,input wire [7:0] reg_wdata,ctrl1_value,
  reg_rdata,input wire [12:0] freq_word);
  wire w2=reg_wr&&reg_addr==3'h2;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_irq_cause: assert property (bitcheck_irq |->
    $past(bitcheck_ok&&ctrl1_value[3:2]==2'h1)) else $error("irq");
  a_fd_manch: assert property (ctrl1_value[3]&&ctrl1_value[1] |=>
    manchester_en) else $error("fd");
  a_clk_off: assert property (w2&&!reg_wdata[1] |-> ##3 !clk_out_en)
    else $error("off");
  a_clk_on: assert property (w2&&reg_wdata[1:0]==2'h3 |-> ##3 clk_out_en)
    else $error("on");
  a_fine_word: assert property (reg_wr&&reg_addr==3'h1 |-> ##3
    freq_word[6:0]==$past(reg_wdata[7:1],3)) else $error("fine");
  a_rd_unmap: assert property (reg_rd&&(reg_addr==3'h0||reg_addr>3'h2) |=>
    reg_rdata==8'h00) else $error("unmap");
  a_rd_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("hold");
  a_range_low: assert property ($past(reset_n)&&!$past(ctrl1_value[5]) |->
    freq_word[12:10]==3'h3) else $error("range");
endmodule // sfc_config_chk
bind sfc_config sfc_config_chk i_sfc_config_chk(.core_clk,.reset_n,.reg_wr,.reg_rd,
  .bitcheck_ok,.bitcheck_irq,.manchester_en,.clk_out_en,.reg_addr,.reg_wdata,.ctrl1_value,
  .reg_rdata,.freq_word);

/* File: sim/tb.sv */
// Bench: reset values, random access, modes, wake events
`timescale 1ns/1ps
module tb;
  reg core_clk=0,reset_n=0,bitcheck_ok=0,active_low_wake_pin=1,power_on_status=0;
  reg [7:0] ctrl1_value=0,q;
  wire [2:0] reg_addr;
  wire [7:0] reg_wdata,reg_rdata;
  wire reg_wr,reg_rd,bitcheck_irq,manchester_en,clk_out_en;
  wire [12:0] freq_word;
  integer err_total=0,total_checks=0,seed=1,i,m,fine=84,opt=0,cb=30,en=1,on=1;
  always #12.5 core_clk=~core_clk;
  sfc_host i_sfc_host(.core_clk,.reg_rdata,.reg_addr,.reg_wdata,.reg_wr,.reg_rd);
  sfc_config i_sfc_config(.core_clk,.reset_n,.reg_addr,.reg_wdata,.reg_wr,.reg_rd,.ctrl1_value,
    .bitcheck_ok,.active_low_wake_pin,.power_on_status,.reg_rdata,.freq_word,.bitcheck_irq,
    .manchester_en,.clk_out_en);
  task cmp(input [31:0] n,input [12:0] e,g); begin
    total_checks=total_checks+1;
    if (g!==e) begin
      err_total=err_total+1;
      $display("mismatch %0s exp %h got %h",n,e,g);
    end
  end endtask
  task x(input [2:0] a,input [7:0] d,input w); i_sfc_host.xfer(a,d,w,q); endtask
  task chk(input [2:0] a); begin
    x(a,8'h00,1'b0);
    cmp("rd",a==1?fine*2+opt:a==2?cb*4+en*2+on:0,q);
    cmp("word",(ctrl1_value[5]?128*cb:3072+128*(cb%8))+fine,freq_word);
    cmp("clk",en&on,clk_out_en);
  end endtask
  task stop_test; begin
    if (err_total==0&&total_checks>0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end endtask
  initial begin
    repeat (3) @(posedge core_clk);
    reset_n<=1'b1;
    chk(3'h1);
    chk(3'h2);
    for (i=0;i<80;i=i+1) begin
      m=$random(seed);
      @(posedge core_clk) ctrl1_value<={2'h0,m[11],5'h00};
      x(m[10:8],m[7:0],1'b1);
      if (m[10:8]==1) begin fine=m[7:1]; opt=m[0]; end
      if (m[10:8]==2) begin cb=m[7:2]; en=m[1]; on=m[0]; end
      chk(m[14:12]);
    end
    for (i=0;i<16;i=i+1) begin
      m=i/2;
      x(3'h2,cb*4+2,1'b1);
      x(3'h1,fine*2+i%2,1'b1);
      en=1;
      on=0;
      opt=i%2;
      @(posedge core_clk) ctrl1_value<=m*2;
      bitcheck_ok<=1'b1;
      @(posedge core_clk) bitcheck_ok<=1'b0;
      #1 cmp("irq",(m==2||m==3)&&!opt,bitcheck_irq);
      if (m==2||m==3) on=1;
      if (m==1||m>4&&m%2) cmp("man",m>1||!opt,manchester_en);
      chk(3'h2);
    end
    for (i=0;i<2;i=i+1) begin
      x(3'h2,8'h02,1'b1);
      cb=0;
      en=1;
      on=0;
      chk(3'h2);
      @(posedge core_clk) if (i) power_on_status<=1'b1; else active_low_wake_pin<=1'b0;
      repeat (5) @(posedge core_clk);
      on=1;
      chk(3'h2);
      @(posedge core_clk) active_low_wake_pin<=1'b1;
    end
    stop_test;
  end
endmodule // tb
